// >>> common/pmc_defines.vh
// Constants for the sequencing control register slice.
// Included by the serial slave and the register slice; holds definitions only.
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PMC_OFS_CTRL2 8'h0E
`define PMC_OFS_CTRL3 8'h0F
`define PMC_OFS_BUCK1 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMC_B_TMR1S 7
`define PMC_B_TMR5S 6
`define PMC_B_MEMVAL 5
`define PMC_B_DSREQ 4
`define PMC_B_B3OVR 3
`define PMC_B_HYST 2
`define PMC_B_EXTFB 7
`define PMC_B_RSVD 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PMC_RST_CTRL2_HI 5'h01
`define PMC_RST_CTRL2_LO 3'h5
`define PMC_RST_CTRL3 8'h1F
`define PMC_RST_B1CODE 6'h3F

// ----------------------------------------
// Sequencing option codes
// ----------------------------------------
`define PMC_SEQ_BUCK_OPT 3'h4
`define PMC_SEQ_LIN_OPT 3'h7

// ----------------------------------------
// Lockout thresholds and hysteresis, mV
// ----------------------------------------
`define PMC_THR_00 13'h0AF0
`define PMC_THR_01 13'h0BB8
`define PMC_THR_10 13'h0C1C
`define PMC_THR_11 13'h0CB2
`define PMC_HYST_0 13'h0190
`define PMC_HYST_1 13'h01F4

// ----------------------------------------
// Voltage code mapping, mV
// ----------------------------------------
`define PMC_V_BASE_LO 13'h02D5
`define PMC_V_STEP_LO 13'h0019
`define PMC_V_BASE_HI 13'h060E
`define PMC_V_STEP_HI 13'h0032
`define PMC_V_SPLIT 6'h20

// ----------------------------------------
// Serial port
// ----------------------------------------
`define PMC_I2C_ADDR 7'h2A

`endif

// >>> src/pmc_sync.v
// Two flip-flop synchroniser for a bundle of unrelated levels.
// Assumes each bit is a slow level from outside the clock domain.
`timescale 1ns/1ps

module pmc_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire nrst_in,
    // Levels
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);

reg [W-1:0] stage;

// First stage feeds only the second
always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        stage <= RST_VAL;
        sync_out <= RST_VAL;
    end else begin
        stage <= async_in;
        sync_out <= stage;
    end
end

endmodule

// >>> src/pmc_i2c_slave.v
// Byte-level serial slave: pointer byte then data, auto-increment.
// Assumes scl and sda already synchronised; sda is open drain.
`timescale 1ns/1ps
`include "pmc_defines.vh"

module pmc_i2c_slave #(
    parameter [6:0] DEV_ADDR = `PMC_I2C_ADDR
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire nrst_in,
    // Synchronised bus lines
    input wire scl_in,
    input wire sda_in,
    output reg sda_oe_out,
    // Register side
    output reg [7:0] ptr_out,
    output reg wr_stb_out,
    output reg [7:0] wr_addr_out,
    output reg [7:0] wr_data_out,
    input wire [7:0] rd_data_in
);

localparam ST_IDLE = 3'h0;
localparam ST_DEV = 3'h1;
localparam ST_ACK = 3'h2;
localparam ST_WR = 3'h3;
localparam ST_RD = 3'h4;
localparam ST_RACK = 3'h5;

reg [2:0] st;
reg [3:0] cnt;
reg [7:0] sh;
reg rw;
reg first;
reg scl_d;
reg sda_d;
wire scl_rise = scl_in & ~scl_d;
wire scl_fall = ~scl_in & scl_d;
wire start_c = scl_in & scl_d & sda_d & ~sda_in;
wire stop_c = scl_in & scl_d & ~sda_d & sda_in;

// Protocol engine; start and stop override any state
always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        st <= ST_IDLE;
        cnt <= 4'h0;
        sh <= 8'h00;
        rw <= 1'b0;
        first <= 1'b0;
        scl_d <= 1'b1;
        sda_d <= 1'b1;
        sda_oe_out <= 1'b0;
        ptr_out <= 8'h00;
        wr_stb_out <= 1'b0;
        wr_addr_out <= 8'h00;
        wr_data_out <= 8'h00;
    end else begin
        scl_d <= scl_in;
        sda_d <= sda_in;
        wr_stb_out <= 1'b0;
        if (start_c) begin
            st <= ST_DEV;
            cnt <= 4'h0;
            first <= 1'b1;
            sda_oe_out <= 1'b0;
        end else if (stop_c) begin
            st <= ST_IDLE;
            sda_oe_out <= 1'b0;
        end else begin
            case (st)
                ST_DEV, ST_WR: begin
                    if (scl_rise) begin
                        sh <= {sh[6:0], sda_in};
                        cnt <= cnt + 4'h1;
                    end else if (scl_fall && cnt == 4'h8) begin
                        cnt <= 4'h0;
                        if (st == ST_DEV) begin
                            // Not our address: stay off the bus
                            if (sh[7:1] == DEV_ADDR) begin
                                rw <= sh[0];
                                sda_oe_out <= 1'b1;
                                st <= ST_ACK;
                            end else begin
                                st <= ST_IDLE;
                            end
                        end else begin
                            if (first) begin
                                ptr_out <= sh;
                                first <= 1'b0;
                            end else begin
                                wr_stb_out <= 1'b1;
                                wr_addr_out <= ptr_out;
                                wr_data_out <= sh;
                                ptr_out <= ptr_out + 8'h01;
                            end
                            sda_oe_out <= 1'b1;
                            st <= ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        cnt <= 4'h0;
                        if (rw) begin
                            sh <= rd_data_in;
                            sda_oe_out <= ~rd_data_in[7];
                            st <= ST_RD;
                        end else begin
                            sda_oe_out <= 1'b0;
                            st <= ST_WR;
                        end
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        cnt <= cnt + 4'h1;
                        if (cnt == 4'h7) begin
                            sda_oe_out <= 1'b0;
                            ptr_out <= ptr_out + 8'h01;
                            st <= ST_RACK;
                        end else begin
                            sda_oe_out <= ~sh[6];
                            sh <= {sh[6:0], 1'b0};
                        end
                    end
                end
                ST_RACK: begin
                    // Master nack ends the read
                    if (scl_rise && sda_in) begin
                        st <= ST_IDLE;
                    end else if (scl_fall) begin
                        cnt <= 4'h0;
                        sh <= rd_data_in;
                        sda_oe_out <= ~rd_data_in[7];
                        st <= ST_RD;
                    end
                end
                default: begin
                    st <= ST_IDLE;
                    sda_oe_out <= 1'b0;
                end
            endcase
        end
    end
end

endmodule

// >>> src/pmc_seq_regs.v
// Sequencing control registers, lockout comparator and rail gating.
// Assumes the sequencing engine, the rail ADC reading and the other
// option registers run on ref_clk_in; pins arrive asynchronously.
`timescale 1ns/1ps
`include "pmc_defines.vh"

module pmc_seq_regs #(
    parameter [6:0] DEV_ADDR = `PMC_I2C_ADDR
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire nrst_in,
    // Serial pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_out,
    // Analog status and straps
    input wire bandgap_ok_in,
    input wire nvm_ext_fb_in,
    input wire buck3_enable_pin_in,
    input wire [12:0] system_rail_mv_in,
    // Sequencing engine
    input wire [2:0] buck_sequence_sel_in,
    input wire [2:0] linreg_sequence_sel_in,
    input wire [4:0] rail_req_in,
    input wire ext_reg_req_in,
    input wire power_good_in,
    // Rail controls
    output reg [4:0] rail_en_out,
    output reg external_regulator_pin_out,
    output reg power_good_out,
    output reg [4:0] discharge_out,
    output reg [2:0] forced_fixed_freq_out,
    // Converter settings
    output reg buck1_ext_fb_out,
    output reg [5:0] buck1_code_out,
    output reg [12:0] buck1_target_mv_out,
    // State
    output reg timer_1s_en_out,
    output reg timer_5s_en_out,
    output reg undervoltage_lockout_out,
    output reg item_a_out
);

// ----------------------------------------
// Reset release and input synchronisers
// ----------------------------------------
reg rst_s1;
reg rst_n;
always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        rst_s1 <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_s1 <= 1'b1;
        rst_n <= rst_s1;
    end
end

wire [4:0] pins_s;
pmc_sync #(.W(5), .RST_VAL(5'h18)) u_sync (
    .ref_clk_in(ref_clk_in),
    .nrst_in(rst_n),
    .async_in({scl_in, sda_in, bandgap_ok_in, nvm_ext_fb_in,
        buck3_enable_pin_in}),
    .sync_out(pins_s)
);
wire scl_s = pins_s[4];
wire sda_s = pins_s[3];
wire bg_ok = pins_s[2];
wire nvm_fb = pins_s[1];
wire b3_pin = pins_s[0];

// ----------------------------------------
// Serial slave
// ----------------------------------------
wire [7:0] ptr;
wire wr_stb;
wire [7:0] wr_addr;
wire [7:0] wr_data;
reg [7:0] rd_data;

pmc_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_i2c (
    .ref_clk_in(ref_clk_in),
    .nrst_in(rst_n),
    .scl_in(scl_s),
    .sda_in(sda_s),
    .sda_oe_out(sda_oe_out),
    .ptr_out(ptr),
    .wr_stb_out(wr_stb),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .rd_data_in(rd_data)
);

// Open drain: only ever pulls low
assign sda_out = 1'b0;

// ----------------------------------------
// Registers
// ----------------------------------------
reg [4:0] ctrl2_hi;     // Timers, memory valid, item_a, override
reg [2:0] ctrl2_lo;     // Hysteresis and threshold
reg [7:0] ctrl3;
reg b1_ext_fb;
reg [5:0] b1_code;
reg strap_done;

wire wr_c2 = wr_stb && (wr_addr == `PMC_OFS_CTRL2);
wire wr_c3 = wr_stb && (wr_addr == `PMC_OFS_CTRL3);
wire wr_b1 = wr_stb && (wr_addr == `PMC_OFS_BUCK1);
wire lockout = undervoltage_lockout_out;

// Lockout-domain bits; reload holds while locked, writes lose
always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        ctrl2_hi <= `PMC_RST_CTRL2_HI;
        ctrl3 <= `PMC_RST_CTRL3;
        b1_ext_fb <= 1'b0;
        b1_code <= `PMC_RST_B1CODE;
        strap_done <= 1'b0;
    end else if (lockout || !strap_done) begin
        // Flag cleared so the host sees the power loss
        ctrl2_hi <= `PMC_RST_CTRL2_HI;
        ctrl3 <= `PMC_RST_CTRL3;
        b1_ext_fb <= nvm_fb;
        b1_code <= `PMC_RST_B1CODE;
        strap_done <= 1'b1;
    end else begin
        // Host write is the only way memory valid gets set
        if (wr_c2) begin
            ctrl2_hi <= wr_data[7:3];
        end
        if (wr_c3) begin
            ctrl3 <= wr_data;
        end
        if (wr_b1) begin
            b1_ext_fb <= wr_data[`PMC_B_EXTFB];
            b1_code <= wr_data[5:0];
        end
    end
end

// Threshold bits survive lockout; only a bandgap drop reloads them
always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        ctrl2_lo <= `PMC_RST_CTRL2_LO;
    end else if (!bg_ok) begin
        ctrl2_lo <= `PMC_RST_CTRL2_LO;
    end else if (wr_c2) begin
        ctrl2_lo <= wr_data[2:0];
    end
end

// Read mux; reserved bit and unmapped offsets read zero
always @* begin
    case (ptr)
        `PMC_OFS_CTRL2: rd_data = {ctrl2_hi, ctrl2_lo};
        `PMC_OFS_CTRL3: rd_data = ctrl3;
        `PMC_OFS_BUCK1: rd_data = {b1_ext_fb, 1'b0, b1_code};
        default: rd_data = 8'h00;
    endcase
end

// ----------------------------------------
// Lockout comparator
// ----------------------------------------
reg [12:0] thr_mv;
reg [12:0] hyst_mv;
always @* begin
    case (ctrl2_lo[1:0])
        2'h0: thr_mv = `PMC_THR_00;
        2'h1: thr_mv = `PMC_THR_01;
        2'h2: thr_mv = `PMC_THR_10;
        default: thr_mv = `PMC_THR_11;
    endcase
    hyst_mv = ctrl2_lo[`PMC_B_HYST] ? `PMC_HYST_1 : `PMC_HYST_0;
end

// Start locked: no rail enable, external regulator pin or power good turns on until the rail is proven good
always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        undervoltage_lockout_out <= 1'b1;
    end else if (undervoltage_lockout_out) begin
        if (bg_ok && system_rail_mv_in >= thr_mv + hyst_mv) begin
            undervoltage_lockout_out <= 1'b0;
        end
    end else if (!bg_ok || system_rail_mv_in < thr_mv) begin
        undervoltage_lockout_out <= 1'b1;
    end
end

// ----------------------------------------
// Rail gating
// ----------------------------------------
// Code to mV mapping; only the buck1 target uses it in this slice
function [12:0] code_to_mv;
    input [5:0] code;
    begin
        if (code < `PMC_V_SPLIT) begin
            code_to_mv = `PMC_V_BASE_LO + {7'h00, code} * `PMC_V_STEP_LO;
        end else begin
            code_to_mv = `PMC_V_BASE_HI +
                {7'h00, code - `PMC_V_SPLIT} * `PMC_V_STEP_HI;
        end
    end
endfunction

wire opt_match = (buck_sequence_sel_in == `PMC_SEQ_BUCK_OPT);
wire ds_c = ctrl2_hi[`PMC_B_DSREQ - 3] && opt_match &&
    (linreg_sequence_sel_in == `PMC_SEQ_LIN_OPT);
reg [4:0] next_rail;

// Rail order: [4] buck1, [3] buck2, [2] buck3, [1] lin1, [0] lin2
always @* begin
    next_rail = rail_req_in;
    if (opt_match) begin
        next_rail[2] = ctrl2_hi[`PMC_B_B3OVR - 3] ? rail_req_in[0] :
            b3_pin;
    end
    if (ds_c) begin
        next_rail = next_rail & 5'h08;
    end
    if (lockout) begin
        next_rail = 5'h00;
    end
end

// Registered outputs
always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        rail_en_out <= 5'h00;
        external_regulator_pin_out <= 1'b0;
        power_good_out <= 1'b0;
        discharge_out <= 5'h00;
        forced_fixed_freq_out <= 3'h0;
        buck1_ext_fb_out <= 1'b0;
        buck1_code_out <= 6'h00;
        buck1_target_mv_out <= 13'h0000;
        timer_1s_en_out <= 1'b0;
        timer_5s_en_out <= 1'b0;
        item_a_out <= 1'b0;
    end else begin
        rail_en_out <= next_rail;
        external_regulator_pin_out <= ext_reg_req_in & ~lockout;
        power_good_out <= power_good_in & ~ds_c & ~lockout;
        discharge_out <= ctrl3[4:0] & ~next_rail;
        // [0] buck1, [1] buck2, [2] buck3
        forced_fixed_freq_out <= ctrl3[7:5];
        buck1_ext_fb_out <= b1_ext_fb;
        buck1_code_out <= b1_code;
        buck1_target_mv_out <= code_to_mv(b1_code);
        timer_1s_en_out <= ctrl2_hi[`PMC_B_TMR1S - 3];
        timer_5s_en_out <= ctrl2_hi[`PMC_B_TMR5S - 3];
        item_a_out <= ds_c;
    end
end

endmodule

// >>> testbench/pmc_seq_regs_sva.sv
// Assertions on the ports of the sequencing register slice.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps

module pmc_seq_regs_sva (
    // Clock and reset
    input wire ref_clk_in,
    input wire nrst_in,
    // Watched inputs
    input wire [12:0] system_rail_mv_in,
    // Watched outputs
    input wire [4:0] rail_en_out,
    input wire power_good_out,
    input wire [4:0] discharge_out,
    input wire [2:0] forced_fixed_freq_out,
    input wire [5:0] buck1_code_out,
    input wire [12:0] buck1_target_mv_out,
    input wire timer_1s_en_out,
    input wire undervoltage_lockout_out,
    input wire item_a_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    // Shared code table, written out independently of the design
    function automatic [12:0] target_of(input [5:0] c);
        target_of = (c < 6'h20) ? 13'h02D5 + 13'h0019 * c
                                : 13'h060E + 13'h0032 * (c - 6'h20);
    endfunction

    // ----------------------------------------
    // Lockout behaviour
    // ----------------------------------------
    chk_lock_rails_off: assert property (
        undervoltage_lockout_out && $past(undervoltage_lockout_out)
        |-> rail_en_out == 5'h00) else $error("rail on during lockout");
    chk_lock_below_min: assert property (
        (system_rail_mv_in < 13'h0AF0) [*4] |-> undervoltage_lockout_out)
        else $error("no lockout below lowest threshold");
    chk_unlock_level: assert property (
        $fell(undervoltage_lockout_out)
        |-> $past(system_rail_mv_in) >= 13'h0C80)
        else $error("lockout left below threshold plus hysteresis");
    chk_lock_reload: assert property (
        undervoltage_lockout_out [*3] |-> !timer_1s_en_out &&
        !item_a_out && forced_fixed_freq_out == 3'h0)
        else $error("control bits not reloaded in lockout");

    // ----------------------------------------
    // Rail gating and converter settings
    // ----------------------------------------
    chk_discharge_off: assert property (
        $stable(rail_en_out) |-> (discharge_out & rail_en_out) == 5'h00)
        else $error("discharge on an enabled rail");
    chk_sleep_pg_low: assert property (
        item_a_out && $past(item_a_out) |-> !power_good_out)
        else $error("power good high in item_a");
    chk_sleep_rails: assert property (
        item_a_out && $past(item_a_out)
        |-> (rail_en_out & 5'h17) == 5'h00)
        else $error("rail other than buck2 on in item_a");
    chk_target_map: assert property (
        !undervoltage_lockout_out && $stable(buck1_code_out)
        |-> buck1_target_mv_out == target_of(buck1_code_out))
        else $error("buck1 target off the shared table");

    // Main scenarios reached
    cover property ($fell(undervoltage_lockout_out));
    cover property ($rose(item_a_out));
    cover property ($changed(forced_fixed_freq_out));
endmodule

bind pmc_seq_regs pmc_seq_regs_sva chk_i (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .system_rail_mv_in(system_rail_mv_in), .rail_en_out(rail_en_out),
    .power_good_out(power_good_out), .discharge_out(discharge_out),
    .forced_fixed_freq_out(forced_fixed_freq_out),
    .buck1_code_out(buck1_code_out),
    .buck1_target_mv_out(buck1_target_mv_out),
    .timer_1s_en_out(timer_1s_en_out),
    .undervoltage_lockout_out(undervoltage_lockout_out),
    .item_a_out(item_a_out));

// >>> testbench/pmc_host_model.sv
// Host processor model: serial master with register write and read.
// Assumes sda has a pull-up; scl is slow against ref_clk_in.
`timescale 1ns/1ps

module pmc_host_model #(
    parameter [6:0] DEV_ADDR = 7'h2A,
    parameter Q = 8
) (
    // Clock
    input wire ref_clk_in,
    // Bus lines
    input wire sda_oe_in,
    output reg scl_out,
    output wire sda_line_out
);
    reg sda_drv;
    integer nack_count;

    // Pull-up: line is low if either party pulls it
    assign sda_line_out = sda_drv & ~sda_oe_in;

    initial begin
        scl_out = 1'b1;
        sda_drv = 1'b1;
        nack_count = 0;
    end

    // ----------------------------------------
    // Bit level, changes only at rising edges
    // ----------------------------------------
    task wait_q;
        repeat (Q) @(posedge ref_clk_in);
    endtask
    // One bit slot: drive d, return the line seen while scl is high
    task bit_slot(input d, output b);
        sda_drv <= d;
        wait_q;
        scl_out <= 1'b1;
        wait_q;
        b = sda_line_out;
        wait_q;
        scl_out <= 1'b0;
        wait_q;
    endtask
    // Sda rises before scl so a repeated start is never seen as a stop
    task start_cond;
        sda_drv <= 1'b1;
        wait_q;
        scl_out <= 1'b1;
        wait_q;
        sda_drv <= 1'b0;
        wait_q;
        scl_out <= 1'b0;
        wait_q;
    endtask
    task stop_cond;
        sda_drv <= 1'b0;
        wait_q;
        scl_out <= 1'b1;
        wait_q;
        sda_drv <= 1'b1;
        wait_q;
    endtask

    // ----------------------------------------
    // Byte and register level
    // ----------------------------------------
    task send_byte(input [7:0] d);
        integer i;
        reg a;
        for (i = 7; i >= 0; i = i - 1) begin
            bit_slot(d[i], a);
        end
        bit_slot(1'b1, a);
        if (a !== 1'b0) begin
            nack_count = nack_count + 1;
        end
    endtask
    task write_reg(input [7:0] p, input [7:0] d);
        start_cond;
        send_byte({DEV_ADDR, 1'b0});
        send_byte(p);
        send_byte(d);
        stop_cond;
    endtask
    // Last byte refused with a nack, then the line is released
    task read_reg(input [7:0] p, output [7:0] d);
        integer i;
        reg a;
        start_cond;
        send_byte({DEV_ADDR, 1'b0});
        send_byte(p);
        start_cond;
        send_byte({DEV_ADDR, 1'b1});
        for (i = 7; i >= 0; i = i - 1) begin
            bit_slot(1'b1, d[i]);
        end
        bit_slot(1'b1, a);
        stop_cond;
    endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the sequencing control register slice.
// Assumes the host model as bus master and a 100 MHz clock.
`timescale 1ns/1ps

module tb_top;
    reg ref_clk_in = 1'b0;
    reg nrst_in, bg, nvm, pin, ereq, pg;
    reg [12:0] rail;
    reg [2:0] bsel, lsel;
    reg [4:0] req;
    wire scl, sda, oe, xpin, pgo, t1, t5, lock, ds, efb;
    wire [4:0] ren, dis;
    wire [2:0] ffm;
    wire [5:0] code;
    wire [12:0] tgt;
    integer errors = 0;
    integer check_count = 0;
    integer i;
    reg [7:0] rd;
    reg [12:0] thr;

    // 10 ns period
    always #5 ref_clk_in = ~ref_clk_in;

    pmc_seq_regs pmc_seq_regs_i (
        .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .scl_in(scl),
        .sda_in(sda), .sda_out(), .sda_oe_out(oe), .bandgap_ok_in(bg),
        .nvm_ext_fb_in(nvm), .buck3_enable_pin_in(pin),
        .system_rail_mv_in(rail), .buck_sequence_sel_in(bsel),
        .linreg_sequence_sel_in(lsel), .rail_req_in(req),
        .ext_reg_req_in(ereq), .power_good_in(pg), .rail_en_out(ren),
        .external_regulator_pin_out(xpin), .power_good_out(pgo),
        .discharge_out(dis), .forced_fixed_freq_out(ffm),
        .buck1_ext_fb_out(efb), .buck1_code_out(code),
        .buck1_target_mv_out(tgt), .timer_1s_en_out(t1),
        .timer_5s_en_out(t5), .undervoltage_lockout_out(lock),
        .item_a_out(ds));
    pmc_host_model pmc_host_model_i (.ref_clk_in(ref_clk_in),
        .sda_oe_in(oe), .scl_out(scl), .sda_line_out(sda));

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task check(input [15:0] seen, input [15:0] exp, input string msg);
        check_count = check_count + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("MISMATCH at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask
    task settle;
        repeat (8) @(posedge ref_clk_in);
    endtask
    task wr(input [7:0] p, input [7:0] d);
        pmc_host_model_i.write_reg(p, d);
        settle;
    endtask
    task wait_unlock;
        integer n;
        n = 0;
        while (lock !== 1'b0 && n < 200) begin
            @(posedge ref_clk_in);
            n = n + 1;
        end
    endtask
    task complete_run;
        $display("Comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task test_defaults;
        bg <= 1'b1;
        rail <= 13'h0DAC;
        wait_unlock;
        check(lock, 1'b0, "unlock at 3.5 V");
        pmc_host_model_i.read_reg(8'h0E, rd);
        check(rd, 8'h0D, "ctrl2 default");
        pmc_host_model_i.read_reg(8'h0F, rd);
        check(rd, 8'h1F, "ctrl3 default");
        pmc_host_model_i.read_reg(8'h10, rd);
        check(rd, 8'hBF, "buck1 default from strap");
        check(dis, 5'h1F, "discharge on idle rails");
        check(tgt, 13'h0C1C, "default target");
        $display("test defaults done");
    endtask
    task test_timers;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                wr(8'h0E, {i[1:0], 6'h0D});
                check({t1, t5}, i[1:0], "timer enables");
            end
            $display("test timers done");
        end
    endtask
    task test_ctrl3;
        wr(8'h0F, 8'hA5);
        check(ffm, 3'h5, "fixed frequency");
        check(dis, 5'h05, "discharge bits");
        wr(8'h0F, 8'h5A);
        check(ffm, 3'h2, "fixed frequency");
        pmc_host_model_i.read_reg(8'h0F, rd);
        check(rd, 8'h5A, "ctrl3 readback");
        $display("test ctrl3 done");
    endtask
    task test_buck1;
        begin
            for (i = 0; i < 64; i = i + 21) begin
                wr(8'h10, {2'h3, i[5:0]});
                thr = (i < 32) ? 725 + 25 * i : 1550 + 50 * (i - 32);
                check(code, i[5:0], "buck1 code");
                check(tgt, thr, "buck1 target");
                check(efb, 1'b1, "external feedback");
                pmc_host_model_i.read_reg(8'h10, rd);
                check(rd, {2'h2, i[5:0]}, "bit 6 reads zero");
            end
            wr(8'h10, 8'h20);
            check(efb, 1'b0, "fixed mode");
            check(tgt, 13'h060E, "code split");
            $display("test buck1 done");
        end
    endtask
    task test_sleep;
        bsel <= 3'h4;
        lsel <= 3'h7;
        req <= 5'h1F;
        ereq <= 1'b1;
        pg <= 1'b1;
        wr(8'h0E, 8'h2D);
        check(ren[2], 1'b1, "override on");
        req <= 5'h1E;
        settle;
        check(ren[2], 1'b0, "override follows lin2");
        wr(8'h0E, 8'h05);
        check(ren[2], 1'b0, "pin low");
        pin <= 1'b1;
        settle;
        check(ren[2], 1'b1, "pin high");
        check(pgo, 1'b1, "normal operation");
        wr(8'h0E, 8'h15);
        check({ds, ren}, 6'h28, "only buck2 in sleep");
        check(xpin, 1'b1, "external regulator kept");
        check(pgo, 1'b0, "power good low");
        wr(8'h0E, 8'h05);
        check(pgo, 1'b1, "leave sleep");
        req <= 5'h00;
        bsel <= 3'h0;
        $display("test sleep done");
    endtask
    task test_lockout;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                thr = (i == 0) ? 2800 : (i == 1) ? 3000 : (i == 2) ? 3100
                                                                  : 3250;
                wr(8'h0E, {5'h05, i[0], i[1:0]});
                rail <= thr - 1;
                settle;
                check(lock, 1'b1, "below threshold");
                rail <= thr + (i[0] ? 499 : 399);
                settle;
                check(lock, 1'b1, "inside hysteresis");
                rail <= thr + (i[0] ? 500 : 400);
                settle;
                check(lock, 1'b0, "above hysteresis");
                pmc_host_model_i.read_reg(8'h0E, rd);
                check(rd, {5'h01, i[0], i[1:0]}, "lockout reload");
            end
            bg <= 1'b0;
            settle;
            check(lock, 1'b1, "bandgap low");
            bg <= 1'b1;
            wait_unlock;
            pmc_host_model_i.read_reg(8'h0E, rd);
            check(rd, 8'h0D, "bandgap reload");
            check(pmc_host_model_i.nack_count, 0, "serial acks");
            $display("test lockout done");
        end
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        nrst_in = 1'b0;
        bg = 1'b0;
        nvm = 1'b1;
        pin = 1'b0;
        ereq = 1'b0;
        pg = 1'b0;
        rail = 13'h0000;
        bsel = 3'h0;
        lsel = 3'h0;
        req = 5'h00;
        repeat (4) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        settle;
        test_defaults;
        test_timers;
        test_ctrl3;
        test_buck1;
        test_sleep;
        test_lockout;
        complete_run;
    end
    // Runs are about 34000 cycles; over twice that means a hang
    initial begin
        repeat (80000) @(posedge ref_clk_in);
        errors = errors + 1;
        $display("MISMATCH at %0t: watchdog expired", $time);
        complete_run;
    end
endmodule
